// ### src/sfr_dev.sv
// Purpose: flash end of the serial read path; decodes read opcodes and streams array bytes
// Assumes: the array sits outside behind an asynchronous read port
// Notes: link pins are sampled by the system clock, so sck must be well below it
// Function
// RL1 - accepts clock modes 0 and 3
// RL2 - legacy read: opcode, address, four dummies
// RL3 - 264 page: ten page, nine byte bits
// RL4 - 256 page: ten page, eight byte bits
// RL5 - address counter advances on its own
// RL6 - page end continues on next page
// RL7 - array end wraps to page zero
// RL8 - chip select rise ends read, floats output
// RL9 - host holds chip select low throughout
// RL10 - reads never touch the data buffer
// RL11 - fast read uses exactly one dummy
// RL12 - slow read has no dummy byte
// RL13 - page read: address, four dummies
// RL14 - one data bit per clock after header
// RL15 - page read wraps within its page
// RL16 - command starts with select fall, opcode
// RL17 - everything travels msb first
// RL18 - address bits above fields ignored
`include "sfr_regs.svh"
`default_nettype none
module sfr_dev (
   // system
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // serial link toward the host
   sfr_if.dev LNK,
   // page size strap, high selects 264-byte pages
   input wire logic PAGE_264,
   // main array read port, data valid while address stands
   output logic [18:0] MEM_ADDR,
   input wire logic [7:0] MEM_DATA,
   // high while array data streams
   output logic READING
);
   // pin synchronisers, one lane each for {sck, cs_n, si}
   logic [2:0] pin_raw; // raw pins
   logic [2:0] s1_q; // first stage, read only by s2_q
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] agree; // stages two and three match
   logic [2:0] filt_q; // accepted levels
   logic [2:0] prev_q; // accepted levels one cycle back

   // decoded link events
   logic sck_rise;
   logic sck_fall;
   logic cs_high;
   logic cs_fall;
   logic si_bit;

   // command decode
   sfr_pkg::sfr_dev_st_t st_q; // command state
   logic [6:0] cnt_q; // header bits received
   logic [6:0] need_q; // header bits before data
   logic [31:0] hdr_q; // header shifter
   logic [7:0] opc_now; // opcode as its last bit arrives
   logic [23:0] addr_now; // address as its last bit arrives
   logic page_rd_q; // page read: wrap inside the page

   // read address counter
   logic [9:0] page_q; // page_number_bits
   logic [8:0] byte_q; // byte_in_page_bits
   logic [8:0] last_byte; // final byte index of a page
   logic at_end; // counter sits on or past page end

   // output shifter
   logic [2:0] bit_q; // index of the next bit to drive
   logic [7:0] dat_q; // byte being shifted out
   logic so_q;
   logic so_oe_n_q;

   assign pin_raw = {LNK.sck, LNK.cs_n, LNK.si};
   assign agree = ~(s2_q ^ s3_q);

   // three-flop synchronisers with agreement filter
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         s1_q <= `SFR_PIN_RST;
         s2_q <= `SFR_PIN_RST;
         s3_q <= `SFR_PIN_RST;
         filt_q <= `SFR_PIN_RST;
         prev_q <= `SFR_PIN_RST;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a glitch seen by one stage only never reaches the decoder
         filt_q <= (agree & s3_q) | (~agree & filt_q);
         prev_q <= filt_q;
      end
   end

   // edges; same rule for both idle levels of sck [RL1]
   assign sck_rise = filt_q[2] & ~prev_q[2];
   assign sck_fall = ~filt_q[2] & prev_q[2];
   assign cs_high = filt_q[1];
   assign cs_fall = ~filt_q[1] & prev_q[1];
   assign si_bit = filt_q[0];

   // bits arriving on this rise complete opcode or address
   assign opc_now = {hdr_q[6:0], si_bit};
   assign addr_now = {hdr_q[22:0], si_bit};

   // command state machine
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_q <= sfr_pkg::SFR_D_IDLE;
         cnt_q <= 7'h00;
         need_q <= `SFR_ADDR_END;
         hdr_q <= 32'h0;
         page_rd_q <= 1'b0;
      end else if (cs_high) begin
         // deselect aborts whatever was going on [RL8]
         st_q <= sfr_pkg::SFR_D_IDLE;
         cnt_q <= 7'h00;
      end else begin
         unique case (st_q)
            sfr_pkg::SFR_D_IDLE: begin
               // only a fresh select fall opens a command
               if (cs_fall) begin
                  st_q <= sfr_pkg::SFR_D_CMD; // [RL16]
                  cnt_q <= 7'h00;
                  need_q <= `SFR_ADDR_END;
               end
            end
            sfr_pkg::SFR_D_CMD: begin
               // falls before the first rise (mode 3) are ignored here
               if (sck_rise) begin
                  hdr_q <= {hdr_q[30:0], si_bit}; // [RL17]
                  cnt_q <= cnt_q + 7'h01;
                  if (cnt_q == `SFR_OPC_BITS - 7'h01) begin
                     need_q <= sfr_pkg::sfr_hdr_bits(opc_now); // [RL2] [RL11] [RL12] [RL13]
                     page_rd_q <= (opc_now == `SFR_OP_PAGE);
                     // anything but a read is sat out until deselect
                     if (!sfr_pkg::sfr_is_read(opc_now)) begin
                        st_q <= sfr_pkg::SFR_D_SKIP; // [RL16]
                     end
                  end
                  // after the last dummy bit, data follows directly
                  if (cnt_q == need_q - 7'h01) begin
                     st_q <= sfr_pkg::SFR_D_DATA; // [RL14]
                  end
               end
            end
            sfr_pkg::SFR_D_DATA: begin
               // streams until deselect; host keeps select low [RL9]
               st_q <= sfr_pkg::SFR_D_DATA;
            end
            sfr_pkg::SFR_D_SKIP: begin
               st_q <= sfr_pkg::SFR_D_SKIP;
            end
         endcase
      end
   end

   // page end depends on the strap
   assign last_byte = PAGE_264 ? `SFR_PAGE_STD - 9'h001 : `SFR_PAGE_BIN - 9'h001;
   // out-of-range start bytes also roll over rather than run off
   assign at_end = (byte_q >= last_byte);

   // read address counter
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         page_q <= 10'h000;
         byte_q <= 9'h000;
      end else if (st_q == sfr_pkg::SFR_D_CMD && sck_rise && cnt_q == `SFR_ADDR_END - 7'h01) begin
         // top address bits beyond the fields are dropped [RL18]
         if (PAGE_264) begin
            page_q <= addr_now[18:9]; // [RL3]
            byte_q <= addr_now[8:0]; // [RL3]
         end else begin
            page_q <= addr_now[17:8]; // [RL4]
            byte_q <= {1'b0, addr_now[7:0]}; // [RL4]
         end
      end else if (st_q == sfr_pkg::SFR_D_DATA && sck_fall && bit_q == 3'h0 && !cs_high) begin
         // step once the last bit of a byte is on the pin [RL5]
         if (at_end) begin
            byte_q <= 9'h000;
            if (!page_rd_q) begin
               // ten-bit page rolls from the last page to zero [RL6] [RL7]
               page_q <= page_q + 10'h001;
            end
            // page read stays on its page [RL15]
         end else begin
            byte_q <= byte_q + 9'h001; // [RL5]
         end
      end
   end

   // serial output; new bit on each falling sck in the data phase
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || cs_high) begin
         so_q <= 1'b0;
         so_oe_n_q <= 1'b1; // [RL8]
         bit_q <= 3'h7;
      end else if (st_q == sfr_pkg::SFR_D_DATA && sck_fall) begin
         so_oe_n_q <= 1'b0; // [RL14]
         bit_q <= bit_q - 3'h1;
         if (bit_q == 3'h7) begin
            so_q <= MEM_DATA[7]; // [RL14] [RL17]
         end else begin
            so_q <= dat_q[bit_q]; // [RL14] [RL17]
         end
      end
   end

   // byte holder; array sampled as its first bit goes out
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         dat_q <= 8'h00;
      end else if (st_q == sfr_pkg::SFR_D_DATA && sck_fall && bit_q == 3'h7 && !cs_high) begin
         dat_q <= MEM_DATA;
      end
   end

   // read-only array port, no buffer path exists [RL10]
   assign MEM_ADDR = {page_q, byte_q};
   assign READING = (st_q == sfr_pkg::SFR_D_DATA);
   assign LNK.so = so_q;
   assign LNK.so_oe_n = so_oe_n_q;
endmodule : sfr_dev
`default_nettype wire

// ### src/sfr_fifo.sv
// Purpose: small flop FIFO for received read bytes
// Assumes: depth is a power of two
// Notes: extra pointer bit tells full from empty
`default_nettype none
module sfr_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // system
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH]; // storage flops
   logic [AW:0] wr_q; // write pointer with wrap bit
   logic [AW:0] rd_q; // read pointer with wrap bit
   logic full;
   logic empty;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem_q[rd_q[AW-1:0]];

   // storage needs no reset; empty flag hides stale words
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // write pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
      end else if (in_valid && !full) begin
         wr_q <= wr_q + 1'b1;
      end
   end

   // read pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q <= '0;
      end else if (out_ready && !empty) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule : sfr_fifo
`default_nettype wire

// ### src/sfr_host.sv
// Purpose: host end; makes sck, sends a read header, collects bytes into a FIFO
// Assumes: the flash end changes so on falling sck edges
// Notes: sck pauses high at a byte boundary while the FIFO is full
`include "sfr_regs.svh"
`default_nettype none
module sfr_host (
   // system
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // serial link toward the flash
   sfr_if.host LNK,
   // idle clock level, high selects mode 3
   input wire logic MODE3,
   // command request
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic [7:0] CMD_OP,
   input wire logic [23:0] CMD_ADDR,
   input wire logic [15:0] CMD_LEN,
   // read byte stream
   output logic RD_VALID,
   input wire logic RD_READY,
   output logic [7:0] RD_DATA,
   // status
   output logic BUSY
);
   sfr_pkg::sfr_host_st_t st_q; // sequencer
   logic [4:0] div_q; // half-period divider
   logic tick; // half period elapsed
   logic stall; // FIFO refuses the held byte
   logic sck_q;
   logic cs_n_q;
   logic mode3_q; // idle level latched per command
   logic [63:0] tx_q; // outgoing header, msb first
   logic [6:0] cnt_q; // header rises seen
   logic [6:0] need_q; // header length
   logic [15:0] len_q; // bytes still to read
   logic [7:0] rx_q; // incoming byte
   logic [2:0] rbit_q; // bits of rx_q filled
   logic push_q; // byte waiting for the FIFO
   logic fifo_in_ready;
   logic so_s1_q;
   logic so_s2_q;
   logic so_s3_q;
   logic so_f_q; // filtered so

   assign stall = push_q & ~fifo_in_ready;
   assign tick = (div_q == 5'(`SFR_SCK_HALF_CYC - 1)) && !stall;
   assign CMD_READY = (st_q == sfr_pkg::SFR_H_IDLE);
   assign BUSY = (st_q != sfr_pkg::SFR_H_IDLE);
   assign LNK.sck = sck_q;
   assign LNK.cs_n = cs_n_q;
   assign LNK.si = tx_q[63]; // [RL17]

   // so synchroniser; level taken when stages two and three agree
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         so_s1_q <= 1'b0;
         so_s2_q <= 1'b0;
         so_s3_q <= 1'b0;
         so_f_q <= 1'b0;
      end else begin
         so_s1_q <= LNK.so;
         so_s2_q <= so_s1_q;
         so_s3_q <= so_s2_q;
         if (so_s2_q == so_s3_q) begin
            so_f_q <= so_s3_q;
         end
      end
   end

   // link clock divider, cleared while idle, frozen while stalled
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || st_q == sfr_pkg::SFR_H_IDLE) begin
         div_q <= 5'h00;
      end else if (!stall) begin
         div_q <= tick ? 5'h00 : div_q + 5'h01;
      end
   end

   // command sequencer
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_q <= sfr_pkg::SFR_H_IDLE;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         mode3_q <= 1'b0;
         tx_q <= 64'h0;
         cnt_q <= 7'h00;
         need_q <= `SFR_ADDR_END;
         len_q <= 16'h0;
      end else begin
         unique case (st_q)
            sfr_pkg::SFR_H_IDLE: begin
               sck_q <= MODE3; // [RL1]
               if (CMD_VALID) begin
                  mode3_q <= MODE3;
                  tx_q <= {CMD_OP, CMD_ADDR, 32'h0}; // [RL16]
                  need_q <= sfr_pkg::sfr_hdr_bits(CMD_OP); // [RL2] [RL11] [RL12] [RL13]
                  len_q <= sfr_pkg::sfr_is_read(CMD_OP) ? CMD_LEN : 16'h0;
                  cnt_q <= 7'h00;
                  cs_n_q <= 1'b0; // [RL16]
                  st_q <= sfr_pkg::SFR_H_XFER;
               end
            end
            sfr_pkg::SFR_H_XFER: begin
               if (tick && !sck_q) begin
                  sck_q <= 1'b1;
                  if (cnt_q != need_q) begin
                     cnt_q <= cnt_q + 7'h01;
                     if (cnt_q == need_q - 7'h01 && len_q == 16'h0) begin
                        st_q <= sfr_pkg::SFR_H_FIN;
                     end
                  end else if (rbit_q == 3'h7) begin
                     len_q <= len_q - 16'h1;
                     if (len_q == 16'h1) begin
                        st_q <= sfr_pkg::SFR_H_FIN;
                     end
                  end
               end else if (tick) begin
                  sck_q <= 1'b0;
                  // first fall of mode 3 precedes any rise, keep the msb
                  if (cnt_q != 7'h00) begin
                     tx_q <= {tx_q[62:0], 1'b0}; // [RL17]
                  end
               end
            end
            sfr_pkg::SFR_H_FIN: begin
               // cs stays low until the last byte is held [RL9]
               if (tick) begin
                  sck_q <= mode3_q; // [RL1]
                  st_q <= sfr_pkg::SFR_H_GAP;
               end
            end
            sfr_pkg::SFR_H_GAP: begin
               // cs high for a whole half period so the flash sees it
               if (tick) begin
                  if (cs_n_q) begin
                     st_q <= sfr_pkg::SFR_H_IDLE;
                  end else begin
                     cs_n_q <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // receive shifter; so settled since the preceding fall
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || st_q == sfr_pkg::SFR_H_IDLE) begin
         rx_q <= 8'h00;
         rbit_q <= 3'h0;
         push_q <= 1'b0;
      end else if (st_q == sfr_pkg::SFR_H_XFER && tick && !sck_q && cnt_q == need_q) begin
         rx_q <= {rx_q[6:0], so_f_q}; // [RL17]
         rbit_q <= rbit_q + 3'h1;
         if (rbit_q == 3'h7) begin
            push_q <= 1'b1;
         end
      end else if (fifo_in_ready) begin
         push_q <= 1'b0;
      end
   end

   // receive FIFO; full stalls the link clock
   sfr_fifo #(
      .WIDTH(8),
      .DEPTH(8)
   ) i_sfr_fifo (
      .clk(CLOCK),
      .rst(SYS_RST),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .in_data(rx_q),
      .out_valid(RD_VALID),
      .out_ready(RD_READY),
      .out_data(RD_DATA)
   );
endmodule : sfr_host
`default_nettype wire

// ### src/sfr_if.sv
// Purpose: serial link between host and flash ends
// Assumes: so carries nothing while so_oe_n is high
// Notes: no clocking block; pure signal bundle
`default_nettype none
interface sfr_if;
   // serial clock from host
   logic sck;
   // chip select, active low
   logic cs_n;
   // serial data toward the flash
   logic si;
   // serial data from the flash
   logic so;
   // so output enable, low while the flash drives
   logic so_oe_n;
   modport dev (input sck, input cs_n, input si, output so, output so_oe_n);
   modport host (output sck, output cs_n, output si, input so);
endinterface : sfr_if
`default_nettype wire

// ### src/sfr_pkg.sv
// Purpose: types and opcode decoding shared by both ends
// Assumes: sfr_regs.svh holds the numbers
// Notes: functions decode the header length used by both ends
`include "sfr_regs.svh"
`default_nettype none
package sfr_pkg;

   // flash-side states
   typedef enum logic [3:0] {
      SFR_D_IDLE = 4'h1,
      SFR_D_CMD = 4'h2,
      SFR_D_DATA = 4'h4,
      SFR_D_SKIP = 4'h8
   } sfr_dev_st_t;

   // host-side states
   typedef enum logic [3:0] {
      SFR_H_IDLE = 4'h1,
      SFR_H_XFER = 4'h2,
      SFR_H_FIN = 4'h4,
      SFR_H_GAP = 4'h8
   } sfr_host_st_t;

   // true for the four array read opcodes
   function automatic logic sfr_is_read(input logic [7:0] op);
      return (op == `SFR_OP_LEGACY) || (op == `SFR_OP_FAST) ||
             (op == `SFR_OP_SLOW) || (op == `SFR_OP_PAGE);
   endfunction : sfr_is_read

   // opcode plus address plus don't-care bits before data
   function automatic logic [6:0] sfr_hdr_bits(input logic [7:0] op);
      logic [2:0] d;
      d = `SFR_DUMMY_SLOW;
      case (op)
         `SFR_OP_LEGACY: d = `SFR_DUMMY_LEGACY; // [RL2]
         `SFR_OP_FAST: d = `SFR_DUMMY_FAST; // [RL11]
         `SFR_OP_PAGE: d = `SFR_DUMMY_PAGE; // [RL13]
         default: d = `SFR_DUMMY_SLOW; // [RL12]
      endcase
      return `SFR_ADDR_END + {1'b0, d, 3'h0};
   endfunction : sfr_hdr_bits

endpackage : sfr_pkg
`default_nettype wire

// ### src/sfr_regs.svh
// Purpose: shared constants of the serial flash read path
// Assumes: included by bare name from package and both ends
// Notes: definitions only, guarded against double inclusion
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// read opcodes
`define SFR_OP_LEGACY 8'he8
`define SFR_OP_FAST 8'h0b
`define SFR_OP_SLOW 8'h03
`define SFR_OP_PAGE 8'hd2

// don't-care bytes that follow the address, per opcode
`define SFR_DUMMY_LEGACY 3'h4
`define SFR_DUMMY_FAST 3'h1
`define SFR_DUMMY_SLOW 3'h0
`define SFR_DUMMY_PAGE 3'h4

// header bit counts
`define SFR_OPC_BITS 7'h08
`define SFR_ADDR_END 7'h20

// bytes per page in the two configurations
`define SFR_PAGE_STD 9'h108
`define SFR_PAGE_BIN 9'h100

// reset level of {sck, cs_n, si} synchroniser stages
`define SFR_PIN_RST 3'h2

// timing: system clock and host-made link clock periods in ns
`define SFR_CLK_NS 4
`define SFR_SCK_NS 160
// half period in system cycles, least time so rounded up
`define SFR_SCK_HALF_CYC ((`SFR_SCK_NS / 2 + `SFR_CLK_NS - 1) / `SFR_CLK_NS)

`endif

// ### verif/serial_flash_read_commands_tb.sv
// Purpose: bench joining host and flash ends
// Assumes: array byte is a fixed address function
// Notes: expected bytes follow page wrap rules
`include "sfr_regs.svh"
`default_nettype none
module serial_flash_read_commands_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0; // system clock
   logic sys_rst = 1'b1; // sync reset
   logic mode3 = 1'b0; // idle sck level
   logic page_264 = 1'b1; // page size strap
   logic cmd_valid = 1'b0; // command request
   logic [7:0] cmd_op = 8'h00;
   logic [23:0] cmd_addr = 24'h000000;
   logic [15:0] cmd_len = 16'h0000;
   logic rd_ready = 1'b1; // drain enable
   logic cmd_ready, rd_valid, busy, reading;
   logic [7:0] rd_data, mem_data;
   logic [18:0] mem_addr;
   logic [7:0] got_q[$]; // popped bytes
   logic seen_q; // data phase seen
   int miscompares = 0;
   int check_count = 0;
   always #2 clock = ~clock;
   // array model: page and byte fold into a byte
   function automatic logic [7:0] arr(input logic [9:0] p, input logic [8:0] b);
      return b[7:0] ^ p[7:0] ^ {b[8], p[9:8], 5'h00};
   endfunction : arr
   assign mem_data = arr(mem_addr[18:9], mem_addr[8:0]);
   sfr_if i_sfr_if ();
   sfr_host i_sfr_host (.CLOCK(clock), .SYS_RST(sys_rst), .LNK(i_sfr_if.host), .MODE3(mode3),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
      .CMD_LEN(cmd_len), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data), .BUSY(busy));
   sfr_dev i_sfr_dev (.CLOCK(clock), .SYS_RST(sys_rst), .LNK(i_sfr_if.dev), .PAGE_264(page_264),
      .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .READING(reading));
   sfr_monitor i_sfr_monitor (.CLOCK(clock), .SYS_RST(sys_rst), .sck(i_sfr_if.sck),
      .cs_n(i_sfr_if.cs_n), .si(i_sfr_if.si), .so(i_sfr_if.so), .so_oe_n(i_sfr_if.so_oe_n));
   // collect pops with the pre-edge values
   always @(posedge clock) begin
      if (rd_valid === 1'b1 && rd_ready) got_q.push_back(rd_data);
      if (reading === 1'b1) seen_q = 1'b1;
   end
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one read, then every byte against the walk
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n, input logic stall);
      logic [9:0] p;
      logic [8:0] b;
      int k;
      p = page_264 ? a[18:9] : a[17:8];
      b = page_264 ? a[8:0] : {1'b0, a[7:0]};
      got_q.delete();
      seen_q = 1'b0;
      rd_ready = !stall;
      repeat (2) tick();
      cmd_op = op;
      cmd_addr = a;
      cmd_len = n;
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      // fifo full: sck must park high
      if (stall) begin
         repeat (7000) tick();
         chk("fifo head", rd_valid, 1'b1);
         chk("parked sck", i_sfr_if.sck, 1'b1);
         chk("still read", reading, 1'b1);
         chk("so driven", i_sfr_if.so_oe_n, 1'b0);
         chk("no accept", cmd_ready, 1'b0);
         rd_ready = 1'b1;
      end
      k = 0;
      while (busy !== 1'b0 && k < 40000) begin
         tick();
         k++;
      end
      // a host that never goes idle counts as a mismatch
      chk("finished", k < 40000, 1'b1);
      repeat (12) tick();
      chk("ready", cmd_ready, 1'b1);
      chk("count", 32'(got_q.size()), n);
      foreach (got_q[i]) begin
         chk("byte", got_q[i], arr(p, b));
         b = b + 9'h001;
         if (b >= (page_264 ? `SFR_PAGE_STD : `SFR_PAGE_BIN)) begin
            b = 9'h000;
            if (op != `SFR_OP_PAGE) p = p + 10'h001;
         end
      end
      chk("so off", i_sfr_if.so_oe_n, 1'b1);
      chk("data phase", seen_q, n != 16'h0000);
   endtask : rd
   // 264 pages, slow read across a page end
   task automatic t_slow_cross();
      rd(`SFR_OP_SLOW, 24'h000b06, 16'h0004, 1'b0);
      $display("done slow_cross");
   endtask : t_slow_cross
   // 256 pages, fast read off the array end
   task automatic t_fast_wrap();
      page_264 = 1'b0;
      rd(`SFR_OP_FAST, 24'hfffffe, 16'h0004, 1'b0);
      $display("done fast_wrap");
   endtask : t_fast_wrap
   // mode 3, legacy read, junk upper bits
   task automatic t_legacy_m3();
      page_264 = 1'b1;
      mode3 = 1'b1;
      rd(`SFR_OP_LEGACY, 24'hf82a07, 16'h0003, 1'b0);
      mode3 = 1'b0;
      $display("done legacy_m3");
   endtask : t_legacy_m3
   // page read stays inside its page
   task automatic t_page_wrap();
      rd(`SFR_OP_PAGE, 24'h07ff07, 16'h0003, 1'b0);
      $display("done page_wrap");
   endtask : t_page_wrap
   // drain held off until the fifo refuses
   task automatic t_stall();
      page_264 = 1'b0;
      rd(`SFR_OP_SLOW, 24'h000100, 16'h000c, 1'b1);
      $display("done stall");
   endtask : t_stall
   // foreign opcode gets no data
   task automatic t_other_op();
      rd(8'h55, 24'h000000, 16'h0000, 1'b0);
      $display("done other_op");
   endtask : t_other_op
   task automatic test_done();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // main sequence
   initial begin
      repeat (2) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      repeat (8) tick();
      t_slow_cross();
      t_fast_wrap();
      t_legacy_m3();
      t_page_wrap();
      t_stall();
      t_other_op();
      test_done();
   end
   // about twice the expected run
   initial begin
      #200us;
      miscompares++;
      test_done();
   end
endmodule : serial_flash_read_commands_tb
`default_nettype wire

// ### verif/sfr_monitor.sv
// Purpose: link checker for the serial read path
// Assumes: fed from the interface signals
// Notes: counts sck rises to know the header
`default_nettype none
module sfr_monitor (
   // system
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   logic sck_q; // sck one cycle back
   logic [5:0] quiet_q; // cycles since sck moved
   logic [7:0] rise_q; // sck rises since select
   logic [7:0] op_q; // first byte on si
   logic [7:0] hdr; // header rises for op_q
   logic is_rd; // op_q is a read
   // quiet time saturates so reset looks settled
   always_ff @(posedge CLOCK) begin
      sck_q <= sck;
      if (SYS_RST) quiet_q <= 6'h3f;
      else if (sck != sck_q) quiet_q <= 6'h00;
      else if (quiet_q != 6'h3f) quiet_q <= quiet_q + 6'h01;
   end
   // raw rises, not the device's filtered view
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || cs_n) begin
         rise_q <= 8'h00;
         op_q <= 8'h00;
      end else if (sck && !sck_q) begin
         if (rise_q != 8'hff) rise_q <= rise_q + 8'h01;
         if (rise_q < 8'h08) op_q <= {op_q[6:0], si};
      end
   end
   // own decode, kept apart from the design's
   always_comb begin
      is_rd = 1'b1;
      case (op_q)
         8'he8, 8'hd2: hdr = 8'h40;
         8'h0b: hdr = 8'h28;
         8'h03: hdr = 8'h20;
         default: begin
            hdr = 8'h20;
            is_rd = 1'b0;
         end
      endcase
   end
   property p_float; $rose(cs_n) |-> ##[1:8] so_oe_n; endproperty
   a_float: assert property (p_float)
      else $error("so kept after deselect");
   property p_cs_quiet; $rose(cs_n) |-> quiet_q >= 6'h13; endproperty
   a_cs_quiet: assert property (p_cs_quiet)
      else $error("deselect amid clocking");
   property p_spacing; $changed(sck) && !cs_n |-> quiet_q >= 6'h13; endproperty
   a_spacing: assert property (p_spacing)
      else $error("sck half too short");
   property p_cs_first; $fell(cs_n) |-> $stable(sck)[*8]; endproperty
   a_cs_first: assert property (p_cs_first)
      else $error("sck moved at select");
   property p_si_hold; $rose(sck) && !cs_n |-> $stable(si)[*4]; endproperty
   a_si_hold: assert property (p_si_hold)
      else $error("si moved near rise");
   property p_so_fall; $changed(so) && !so_oe_n && !$past(so_oe_n) |-> !sck; endproperty
   a_so_fall: assert property (p_so_fall)
      else $error("so moved with sck high");
   property p_hdr; $fell(so_oe_n) |-> is_rd && rise_q == hdr; endproperty
   a_hdr: assert property (p_hdr)
      else $error("data began at wrong bit");
   property p_nord; !cs_n && rise_q >= 8'h08 && !is_rd |-> so_oe_n; endproperty
   a_nord: assert property (p_nord)
      else $error("so driven for other op");
endmodule : sfr_monitor
`default_nettype wire
